/* emc_pkg.sv */
// Shared constants for the extension mode control block
package emc_pkg;

  // Control port geometry
  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;

  // Data path widths
  localparam int IN_W = 12;
  localparam int OUT_W = 24;

  // Extension register address on the control port
  localparam logic [8:0] EXT_ADDR = 9'h00C;

  // Field positions inside the extension register
  localparam int BIT_INV_AIN = 0;
  localparam int BIT_INV_BIN = 1;
  localparam int BIT_INV_AOUT = 2;
  localparam int BIT_INV_BOUT = 3;
  localparam int BIT_DET_OFF = 4;
  localparam int BIT_FORCE_PD = 5;
  localparam int BIT_PD_STAT = 8;

  // Writable field width and reset value
  localparam logic [5:0] CTL_RESET = 6'h00;
  localparam int CTL_W = 6;

  // Clock period and clock loss time
  localparam int CLK_PERIOD_NS = 8;
  localparam int LOSS_TIME_NS = 1000;
  // Least time, so round up to whole cycles
  localparam int LOSS_CYC = (LOSS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  localparam logic [7:0] LOSS_CNT = 8'(LOSS_CYC);

  // Strobe mode selection states
  typedef enum logic [1:0] {
    MODE_STRAP = 2'b00,
    MODE_LEGACY = 2'b01,
    MODE_MEMORY = 2'b10
  } emc_mode_type;

endpackage

/* emc_extension_mode_control.sv */
// How it works
// (R1) Four bits at address 12 invert data MSBs
// (R2) Inversion bits clear at reset: two's complement
// (R3) Stopped filter clock forces static power down
// (R4) Power down ends itself when clock resumes
// (R5) Detector-off bit stops automatic clock-loss power down
// (R6) Force bit powers down regardless of clock
// (R7) Detector-off and force bits clear at reset
// (R8) Read strobe grounded: legacy read/write and select
// (R9) Otherwise separate read, write, enable strobes
// (R10) Extension register lives only at address 12
// (R11) Host writes with enable and write strobe low
`timescale 1ns/100ps
`default_nettype none

module emc_extension_mode_control (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control port
  input wire logic [8:0] ctl_addr,
  input wire logic [15:0] ctl_data_in,
  output logic [15:0] ctl_data_out,
  output logic ctl_data_oe,
  input wire logic chip_enable_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  // Filter clock under watch
  input wire logic filt_clk_in,
  // Input data paths
  input wire logic [11:0] a_in,
  input wire logic [11:0] b_in,
  output logic [11:0] a_in_fmt,
  output logic [11:0] b_in_fmt,
  // Output data paths
  input wire logic [23:0] a_res,
  input wire logic [23:0] b_res,
  output logic [23:0] a_out,
  output logic [23:0] b_out,
  // Power state
  output logic power_down
);

  // Strobe mode held after reset release
  emc_pkg::emc_mode_type mode_q;
  // Writable extension bits
  logic [5:0] ctl_q;
  // Previous filter clock level
  logic clk_prev_q;
  // Cycles since the last filter clock edge
  logic [7:0] idle_cnt_q;
  // Power down state
  logic pd_q;
  // Decoded strobes
  logic wr_act;
  logic rd_act;
  logic hit;
  logic clk_edge;
  logic lost;
  logic pd_d;

  // MSB inversion helper for any width up to 24 bits
  function automatic logic [23:0] flip_msb(input logic [23:0] v, input int w,
                                           input logic en);
    logic [23:0] r;
    r = v;
    if (en) begin
      r[w-1] = ~v[w-1];
    end
    return r;
  endfunction

  // Mode latch: strap sampled on the first edge after reset release
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_q <= emc_pkg::MODE_STRAP;
    end else begin
      case (mode_q)
        // Grounded read strobe picks legacy mode
        emc_pkg::MODE_STRAP: begin
          if (!read_strobe_n) begin
            mode_q <= emc_pkg::MODE_LEGACY; // [R8]
          end else begin
            mode_q <= emc_pkg::MODE_MEMORY; // [R9]
          end
        end
        // Modes stay until the next reset
        emc_pkg::MODE_LEGACY: mode_q <= emc_pkg::MODE_LEGACY;
        emc_pkg::MODE_MEMORY: mode_q <= emc_pkg::MODE_MEMORY;
        default: mode_q <= emc_pkg::MODE_STRAP;
      endcase
    end
  end

  // Strobe decode per mode
  always_comb begin
    wr_act = 1'b0;
    rd_act = 1'b0;
    if (mode_q == emc_pkg::MODE_LEGACY) begin
      // Write pin acts as read/write select, enable as select
      wr_act = !chip_enable_n && !write_strobe_n; // [R8]
      rd_act = !chip_enable_n && write_strobe_n; // [R8]
    end else if (mode_q == emc_pkg::MODE_MEMORY) begin
      // Separate memory style strobes
      wr_act = !chip_enable_n && !write_strobe_n; // [R9] [R11]
      rd_act = !chip_enable_n && !read_strobe_n && write_strobe_n; // [R9]
    end
  end

  // Address match to the extension register only
  assign hit = (ctl_addr == emc_pkg::EXT_ADDR); // [R10]

  // Extension register: follows data while both strobes are low
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctl_q <= emc_pkg::CTL_RESET; // [R2] [R7]
    end else if (wr_act && hit) begin
      ctl_q <= ctl_data_in[5:0]; // [R1] [R5] [R6] [R11]
    end
  end

  // Read back: register bits plus power down status
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctl_data_out <= 16'h0000;
      ctl_data_oe <= 1'b0;
    end else begin
      ctl_data_oe <= rd_act && hit; // [R10]
      ctl_data_out <= 16'h0000;
      if (rd_act && hit) begin
        ctl_data_out[5:0] <= ctl_q;
        ctl_data_out[emc_pkg::BIT_PD_STAT] <= pd_q;
      end
    end
  end

  // Filter clock edge seen on the sampled pin
  assign clk_edge = (filt_clk_in != clk_prev_q);
  assign lost = (idle_cnt_q == emc_pkg::LOSS_CNT);

  // Idle counter: saturates once the clock counts as lost
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      clk_prev_q <= 1'b0;
      idle_cnt_q <= 8'h00;
    end else begin
      clk_prev_q <= filt_clk_in;
      if (clk_edge) begin
        idle_cnt_q <= 8'h00; // [R4]
      end else if (!lost) begin
        idle_cnt_q <= idle_cnt_q + 8'h01; // [R3]
      end
    end
  end

  // Power down decision
  always_comb begin
    pd_d = 1'b0;
    if (ctl_q[emc_pkg::BIT_FORCE_PD]) begin
      pd_d = 1'b1; // [R6]
    end else if (!ctl_q[emc_pkg::BIT_DET_OFF]) begin
      // Leaves by itself as soon as an edge clears the count
      pd_d = lost && !clk_edge; // [R3] [R4] [R5]
    end
  end

  // Power state register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pd_q <= 1'b0; // [R7]
    end else begin
      pd_q <= pd_d;
    end
  end

  assign power_down = pd_q;

  // Input paths: MSB inversion, frozen while powered down
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      a_in_fmt <= 12'h000;
      b_in_fmt <= 12'h000;
    end else if (!pd_q) begin
      // Helper works at full width; keep only the input word on purpose
      a_in_fmt <= 12'(flip_msb({12'h000, a_in}, emc_pkg::IN_W,
                               ctl_q[emc_pkg::BIT_INV_AIN])); // [R1]
      b_in_fmt <= 12'(flip_msb({12'h000, b_in}, emc_pkg::IN_W,
                               ctl_q[emc_pkg::BIT_INV_BIN])); // [R1]
    end
  end

  // Output paths: MSB inversion, frozen while powered down
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      a_out <= 24'h000000;
      b_out <= 24'h000000;
    end else if (!pd_q) begin
      a_out <= flip_msb(a_res, emc_pkg::OUT_W, ctl_q[emc_pkg::BIT_INV_AOUT]); // [R1]
      b_out <= flip_msb(b_res, emc_pkg::OUT_W, ctl_q[emc_pkg::BIT_INV_BOUT]); // [R1]
    end
  end

  // Checks on the block's own behaviour
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Clock counted as lost with no filter clock edge in this cycle
  sequence s_clock_quiet;
    !clk_edge && lost;
  endsequence

  a_reset_inv_clear: assert property ( // [R2]
    $past(rst) |-> (ctl_q[3:0] == 4'h0) && (a_in_fmt[11] == 1'b0))
    else $error("inversion bits not clear after reset");

  a_reset_pd_clear: assert property ( // [R7]
    $past(rst) |-> !ctl_q[emc_pkg::BIT_DET_OFF] && !ctl_q[emc_pkg::BIT_FORCE_PD])
    else $error("power bits not clear after reset");

  a_ext_write_take: assert property ( // [R10]
    (wr_act && hit) |=> (ctl_q == $past(ctl_data_in[5:0])))
    else $error("extension write not taken");

  a_other_addr_keep: assert property ( // [R10]
    !(wr_act && hit) |=> $stable(ctl_q))
    else $error("extension register changed without write");

  a_ain_msb_flip: assert property ( // [R1]
    !pd_q |=> a_in_fmt == {$past(a_in[11]) ^ $past(ctl_q[0]), $past(a_in[10:0])})
    else $error("path A input format wrong");

  a_bout_msb_flip: assert property ( // [R1]
    !pd_q |=> b_out == {$past(b_res[23]) ^ $past(ctl_q[3]), $past(b_res[22:0])})
    else $error("path B output format wrong");

  a_loss_enter_pd: assert property ( // [R3]
    (s_clock_quiet ##0 !ctl_q[emc_pkg::BIT_DET_OFF]) |=> pd_q)
    else $error("no power down on clock loss");

  // A write that sets the force bit at the same edge is a different story
  a_resume_leave_pd: assert property ( // [R4]
    (pd_q && clk_edge && !ctl_q[emc_pkg::BIT_FORCE_PD] && !(wr_act && hit))
      |=> !pd_q ##1 !pd_q[*1])
    else $error("power down kept after clock resumed");

  a_detect_off_hold: assert property ( // [R5]
    (ctl_q[emc_pkg::BIT_DET_OFF] && !ctl_q[emc_pkg::BIT_FORCE_PD]) |=> !pd_q)
    else $error("power down while detector off");

  a_force_pd: assert property ( // [R6]
    ctl_q[emc_pkg::BIT_FORCE_PD] |=> pd_q)
    else $error("forced power down missing");

  // The strap edge itself still shows the strap state, so skip it
  a_legacy_strap: assert property ( // [R8]
    (!$past(rst) && $past(mode_q) == emc_pkg::MODE_STRAP && !$past(read_strobe_n))
      |-> mode_q == emc_pkg::MODE_LEGACY)
    else $error("legacy mode not latched");

  a_memory_strap: assert property ( // [R9]
    (!$past(rst) && $past(mode_q) == emc_pkg::MODE_STRAP && $past(read_strobe_n))
      |-> mode_q == emc_pkg::MODE_MEMORY)
    else $error("memory mode not latched");

  // Strobe decode checks
  // Read of the extension register taken at this edge
  sequence s_ext_read;
    rd_act && hit;
  endsequence

  a_strap_no_access: assert property ( // [R8]
    (mode_q == emc_pkg::MODE_STRAP) |=> $stable(ctl_q) && !ctl_data_oe)
    else $error("access taken during strap cycle");

  a_memory_read_gate: assert property ( // [R9]
    (mode_q == emc_pkg::MODE_MEMORY && read_strobe_n) |=> !ctl_data_oe)
    else $error("memory mode read without read strobe");

  a_legacy_read_sel: assert property ( // [R8]
    (mode_q == emc_pkg::MODE_LEGACY && !chip_enable_n && write_strobe_n && hit)
      |=> ctl_data_oe)
    else $error("legacy read select not honoured");

  a_read_back_data: assert property ( // [R1]
    s_ext_read |=> (ctl_data_out[5:0] == $past(ctl_q))
      && (ctl_data_out[emc_pkg::BIT_PD_STAT] == $past(pd_q)))
    else $error("extension read data wrong");

  a_other_read_quiet: assert property ( // [R10]
    !(rd_act && hit) |=> !ctl_data_oe && (ctl_data_out == 16'h0000))
    else $error("read data driven for other address");

  // Power state checks
  a_pd_reset_low: assert property ( // [R7]
    $past(rst) |-> !pd_q)
    else $error("power down set after reset");

  // Static state: nothing on the data paths may move
  a_pd_paths_frozen: assert property ( // [R3]
    pd_q |=> $stable(a_out) && $stable(b_out) && $stable(a_in_fmt) && $stable(b_in_fmt))
    else $error("data paths moved while powered down");

  // Remaining data path format checks
  a_bin_msb_flip: assert property ( // [R1]
    !pd_q |=> b_in_fmt == {$past(b_in[11]) ^ $past(ctl_q[1]), $past(b_in[10:0])})
    else $error("path B input format wrong");

  a_aout_msb_flip: assert property ( // [R1]
    !pd_q |=> a_out == {$past(a_res[23]) ^ $past(ctl_q[2]), $past(a_res[22:0])})
    else $error("path A output format wrong");

endmodule // emc_extension_mode_control

`default_nettype wire

/* emc_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Processor on the control port; drives only after the falling edge
module emc_host_model (
  // Clock
  input wire logic ref_clk,
  // Control port
  output logic [8:0] ctl_addr,
  output logic [15:0] ctl_data_in,
  output logic chip_enable_n,
  output logic write_strobe_n,
  output logic read_strobe_n,
  input wire logic [15:0] ctl_data_out,
  input wire logic ctl_data_oe
);
  bit lg = 1'b0;
  initial begin
    ctl_addr = 9'h000;
    ctl_data_in = 16'h0000;
    chip_enable_n = 1'b1;
    write_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
  end
  // Rest state; released buses show inverted content, not stale values
  task idle(input bit leg);
    lg = leg;
    chip_enable_n = 1'b1;
    write_strobe_n = 1'b1;
    read_strobe_n = !lg;
    ctl_addr = ~ctl_addr;
    ctl_data_in = ~ctl_data_in;
  endtask
  // Enable and write strobe low across one rising edge
  task wr(input logic [8:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    ctl_addr = a;
    ctl_data_in = d;
    chip_enable_n = 1'b0;
    write_strobe_n = 1'b0;
    @(negedge ref_clk);
    idle(lg);
  endtask
  // Read held across two rising edges, answer taken after the second
  task rd(input logic [8:0] a, output logic [15:0] d, output logic oe);
    @(negedge ref_clk);
    ctl_addr = a;
    chip_enable_n = 1'b0;
    read_strobe_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    d = ctl_data_out;
    oe = ctl_data_oe;
    idle(lg);
  endtask
endmodule // emc_host_model
`default_nettype wire

/* test_extension_mode_control.sv */
`timescale 1ns/100ps
`default_nettype none
module test_extension_mode_control;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic filt_clk_in = 1'b0;
  logic filt_run = 1'b1;
  logic [11:0] a_in = 12'h000;
  logic [11:0] b_in = 12'h000;
  logic [23:0] a_res = 24'h000000;
  logic [23:0] b_res = 24'h000000;
  logic [8:0] ctl_addr;
  logic [15:0] ctl_data_in, ctl_data_out, rdat;
  logic ctl_data_oe, chip_enable_n, write_strobe_n, read_strobe_n, power_down, roe;
  logic [11:0] a_in_fmt, b_in_fmt;
  logic [23:0] a_out, b_out;
  int num_errors = 0;
  int n_tests = 0;
  always #4 ref_clk = ~ref_clk;
  // Watched clock toggles every cycle while running
  always @(negedge ref_clk) if (filt_run) filt_clk_in <= ~filt_clk_in;
  emc_extension_mode_control dut (.ref_clk(ref_clk), .rst(rst), .ctl_addr(ctl_addr),
    .ctl_data_in(ctl_data_in), .ctl_data_out(ctl_data_out), .ctl_data_oe(ctl_data_oe),
    .chip_enable_n(chip_enable_n), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .filt_clk_in(filt_clk_in), .a_in(a_in), .b_in(b_in),
    .a_in_fmt(a_in_fmt), .b_in_fmt(b_in_fmt), .a_res(a_res), .b_res(b_res),
    .a_out(a_out), .b_out(b_out), .power_down(power_down));
  emc_host_model host (.ref_clk(ref_clk), .ctl_addr(ctl_addr), .ctl_data_in(ctl_data_in),
    .chip_enable_n(chip_enable_n), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .ctl_data_out(ctl_data_out), .ctl_data_oe(ctl_data_oe));
  // Compare and count
  task chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Reset for 5 cycles with the read strobe strapped as asked
  task do_reset(input bit leg);
    rst = 1'b1;
    // Let the previous bus release stand one cycle before re-strapping
    @(negedge ref_clk);
    host.idle(leg);
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask
  // Read an address and compare enable plus data
  task rchk(input logic [8:0] a, input logic [16:0] exp);
    host.rd(a, rdat, roe);
    chk("read", {7'h00, roe, rdat}, {7'h00, exp});
  endtask
  // Drive all four words, compare one cycle later with the chosen MSB flips
  task chk_path(input logic [3:0] inv);
    @(negedge ref_clk);
    a_in = 12'hA5C;
    b_in = 12'h35A;
    a_res = 24'hC0FFEE;
    b_res = 24'h123456;
    @(negedge ref_clk);
    chk("a_in_fmt", {12'h000, a_in_fmt}, {12'h000, a_in[11] ^ inv[0], a_in[10:0]});
    chk("b_in_fmt", {12'h000, b_in_fmt}, {12'h000, b_in[11] ^ inv[1], b_in[10:0]});
    chk("a_out", a_out, {a_res[23] ^ inv[2], a_res[22:0]});
    chk("b_out", b_out, {b_res[23] ^ inv[3], b_res[22:0]});
  endtask
  // Clock loss: stop the watched clock and sample power state
  task stop_clk(input int n, input logic exp);
    filt_run = 1'b0;
    repeat (n) @(negedge ref_clk);
    chk("power_down", {23'h0, power_down}, {23'h0, exp});
  endtask
  initial begin
    do_reset(1'b0);
    rchk(9'h00C, 17'h10000);
    chk_path(4'h0);
    host.wr(9'h00C, 16'hFFCF);
    rchk(9'h00C, 17'h1000F);
    chk_path(4'hF);
    host.wr(9'h00D, 16'h0000);
    host.wr(9'h10C, 16'h0000);
    rchk(9'h00C, 17'h1000F);
    rchk(9'h00D, 17'h00000);
    host.wr(9'h00C, 16'h0000);
    stop_clk(110, 1'b0);
    stop_clk(30, 1'b1);
    filt_run = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("wake", {23'h0, power_down}, 24'h0);
    host.wr(9'h00C, 16'h0010);
    stop_clk(140, 1'b0);
    filt_run = 1'b1;
    host.wr(9'h00C, 16'h0020);
    repeat (2) @(negedge ref_clk);
    chk("forced", {23'h0, power_down}, 24'h1);
    rchk(9'h00C, 17'h10120);
    do_reset(1'b1);
    rchk(9'h00C, 17'h10000);
    host.wr(9'h00C, 16'h0005);
    rchk(9'h00C, 17'h10005);
    chk_path(4'h5);
    finish_test;
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #20000;
    num_errors++;
    finish_test;
  end
endmodule // test_extension_mode_control
`default_nettype wire
